//--- logic/cu_chain_defines.vh
// constants for the command chain sequencer
`ifndef CU_CHAIN_DEFINES_VH
`define CU_CHAIN_DEFINES_VH
// ==========================================
// register byte offsets
`define CCX_CTRL_OFS     5'h00
`define CCX_PTR_OFS      5'h04
`define CCX_BASE_OFS     5'h08
`define CCX_STAT_OFS     5'h0C
`define CCX_TXCNT_OFS    5'h10
// ==========================================
// control register fields
`define CCX_CTRL_START   0
`define CCX_CTRL_RESUME  1
`define CCX_CTRL_CNA_EN  2
// ==========================================
// command block layout and fields
`define CB_CTL_OFS       32'h0000_0000
`define CB_LINK_OFS      32'h0000_0004
`define CB_PARAM_OFS     32'h0000_0008
`define CB_WORDS         3'h4
`define CB_EL_BIT        31
`define CB_S_BIT         30
`define CB_I_BIT         29
`define CB_OP_HI         18
`define CB_OP_LO         16
`define CB_C_BIT         15
`define CB_OK_BIT        13
// ==========================================
// opcodes
`define OP_NOP           3'h0
`define OP_IA            3'h1
`define OP_CONFIG        3'h2
`define OP_MCAST         3'h3
`define OP_TX            3'h4
`define OP_UCODE         3'h5
`define OP_DUMP          3'h6
`define OP_DIAG          3'h7
// ==========================================
// reset values
`define CFG_RESET        64'h0000_0000_0000_0000
`define CFG_PHY_BIT      0
`define IA_RESET         48'hFFFF_FFFF_FFFF
// ==========================================
// command unit states as reported
`define CU_IDLE          2'h0
`define CU_SUSP          2'h1
`define CU_ACTIVE        2'h2
`endif

//--- logic/command_chain_executor.v
// command unit: fetches, runs and completes the command chain
`timescale 1ns/10ps
`include "cu_chain_defines.vh"
module command_chain_executor
(
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [4:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// host memory master
	output reg         mem_req,
	output reg         mem_we,
	output reg         mem_burst,
	output reg  [3:0]  mem_be,
	output reg  [31:0] mem_addr,
	output reg  [31:0] mem_wdata,
	input  wire        mem_ack,
	input  wire [31:0] mem_rdata,
	// neighbours
	input  wire        rx_busy,
	input  wire        phy_mode_strap,
	output reg         tx_dma_req,
	input  wire        tx_dma_done,
	input  wire        tx_frame_sent,
	output reg         diag_req,
	input  wire        diag_done,
	input  wire        diag_fail,
	output reg         ucode_load,
	output reg         mcast_load,
	output reg  [63:0] param_data,
	output reg  [47:0] station_addr,
	output reg  [63:0] config_data,
	// system control block events
	output reg         completion_interrupt,
	output reg         not_active_interrupt,
	output reg  [1:0]  cu_state
);
	localparam [3:0] S_IDLE = 4'h0, S_SUSP = 4'h1, S_FETCH = 4'h2, S_DECODE = 4'h3,
		S_PREF = 4'h4, S_ACT = 4'h5, S_WAIT = 4'h6, S_DUMP = 4'h7, S_STWR = 4'h8, S_DONE = 4'h9;

	// ==========================================
	// apb registers
	wire        wr_en  = psel & penable & pwrite;
	wire        rd_setup = psel & ~penable & ~pwrite;
	wire        mapped = (paddr == `CCX_CTRL_OFS) || (paddr == `CCX_PTR_OFS) ||
		(paddr == `CCX_BASE_OFS) || (paddr == `CCX_STAT_OFS) || (paddr == `CCX_TXCNT_OFS);
	reg         cna_en_reg;
	reg         start_reg;
	reg         resume_reg;
	reg  [31:0] ptr_reg;
	reg  [31:0] base_reg;
	reg  [31:0] tx_count_reg;
	reg  [15:0] last_status_reg;
	reg  [3:0]  next_fields_reg;
	reg  [2:0]  next_op_reg;
	reg         prefetched_reg;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cna_en_reg <= 1'b0;
			ptr_reg    <= 32'h0000_0000;
			base_reg   <= 32'h0000_0000;
		end
		else if (wr_en)
		begin
			if (paddr == `CCX_CTRL_OFS)
				cna_en_reg <= pwdata[`CCX_CTRL_CNA_EN];
			else if (paddr == `CCX_PTR_OFS)
				ptr_reg <= pwdata;
			else if (paddr == `CCX_BASE_OFS)
				base_reg <= pwdata;
		end
	end

	// read data latched in the setup cycle keeps the access phase zero-wait;
	// the value returned is the one of the setup cycle
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
		begin
			if (paddr == `CCX_CTRL_OFS)
				prdata <= {29'h0000000, cna_en_reg, 2'h0};
			else if (paddr == `CCX_PTR_OFS)
				prdata <= ptr_reg;
			else if (paddr == `CCX_BASE_OFS)
				prdata <= base_reg;
			else if (paddr == `CCX_STAT_OFS)
				prdata <= {prefetched_reg, next_fields_reg, next_op_reg, 6'h00, cu_state, last_status_reg};
			else if (paddr == `CCX_TXCNT_OFS)
				prdata <= tx_count_reg;
			else
				prdata <= 32'h0000_0000;
		end
		else
			prdata <= 32'h0000_0000;
	end

	// start and resume are held until the unit can act on them
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_reg  <= 1'b0;
			resume_reg <= 1'b0;
		end
		else
		begin
			if (wr_en && paddr == `CCX_CTRL_OFS && pwdata[`CCX_CTRL_START])
				start_reg <= 1'b1;
			else if (start_reg && cu_state != `CU_ACTIVE && !rx_busy)
				start_reg <= 1'b0;
			if (wr_en && paddr == `CCX_CTRL_OFS && pwdata[`CCX_CTRL_RESUME])
				resume_reg <= 1'b1;
			else if (resume_reg && cu_state == `CU_SUSP && !rx_busy)
				resume_reg <= 1'b0;
		end
	end

	// final wire results only counted here, never in the block
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_count_reg <= 32'h0000_0000;
		else if (tx_frame_sent)
			tx_count_reg <= tx_count_reg + 32'h0000_0001;
	end

	// ==========================================
	// strap capture after reset release
	reg strap_s1_reg;
	reg strap_s2_reg;
	reg strap_done_reg;
	reg [1:0] strap_wait_reg;
	// capture only once both stages hold the pin, not their reset value
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_s1_reg   <= 1'b0;
			strap_s2_reg   <= 1'b0;
			strap_wait_reg <= 2'h0;
		end
		else
		begin
			strap_s1_reg <= phy_mode_strap;
			strap_s2_reg <= strap_s1_reg;
			if (strap_wait_reg != 2'h2)
				strap_wait_reg <= strap_wait_reg + 2'h1;
		end
	end

	// ==========================================
	// command sequencer
	reg  [3:0]  state;
	reg  [2:0]  word_cnt;
	reg  [31:0] cb_addr;
	reg  [31:0] cb_ctl;
	reg  [31:0] cb_link;
	reg  [31:0] cb_p0;
	reg  [31:0] cb_p1;
	reg         ok_reg;
	wire [2:0]  opcode = cb_ctl[`CB_OP_HI:`CB_OP_LO];
	wire        last   = cb_ctl[`CB_EL_BIT];
	wire        susp   = cb_ctl[`CB_S_BIT];
	wire        go_new = start_reg && cu_state != `CU_ACTIVE && !rx_busy;
	wire        go_res = resume_reg && cu_state == `CU_SUSP && !rx_busy;

	function [31:0] dump_word;
		input [2:0] idx;
		begin
			if (idx == 3'h0)
				dump_word = config_data[31:0];
			else if (idx == 3'h1)
				dump_word = config_data[63:32];
			else if (idx == 3'h2)
				dump_word = station_addr[31:0];
			else
				dump_word = {tx_count_reg[15:0], station_addr[47:32]};
		end
	endfunction

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			cu_state <= `CU_IDLE;
			word_cnt <= 3'h0;
			cb_addr <= 32'h0000_0000;
			cb_ctl <= 32'h0000_0000;
			cb_link <= 32'h0000_0000;
			cb_p0 <= 32'h0000_0000;
			cb_p1 <= 32'h0000_0000;
			ok_reg <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_burst <= 1'b0;
			mem_be <= 4'h0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
			tx_dma_req <= 1'b0;
			diag_req <= 1'b0;
			ucode_load <= 1'b0;
			mcast_load <= 1'b0;
			param_data <= 64'h0000_0000_0000_0000;
			station_addr <= `IA_RESET;
			config_data <= `CFG_RESET;
			strap_done_reg <= 1'b0;
			completion_interrupt <= 1'b0;
			not_active_interrupt <= 1'b0;
			last_status_reg <= 16'h0000;
			next_fields_reg <= 4'h0;
			next_op_reg <= 3'h0;
			prefetched_reg <= 1'b0;
		end
		else
		begin
			ucode_load <= 1'b0;
			mcast_load <= 1'b0;
			completion_interrupt <= 1'b0;
			not_active_interrupt <= 1'b0;
			if (!strap_done_reg && strap_wait_reg == 2'h2)
			begin
				// default parameters except the phy mode strap
				strap_done_reg <= 1'b1;
				config_data[`CFG_PHY_BIT] <= strap_s2_reg;
			end
			case (state)
				S_IDLE, S_SUSP:
				begin
					if (go_new || go_res)
					begin
						cb_addr <= go_new ? base_reg + ptr_reg : cb_addr;
						mem_addr <= go_new ? base_reg + ptr_reg + `CB_CTL_OFS : cb_addr + `CB_CTL_OFS;
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_burst <= 1'b1;
						mem_be <= 4'hF;
						word_cnt <= 3'h0;
						cu_state <= `CU_ACTIVE;
						state <= S_FETCH;
					end
				end
				S_FETCH:
				begin
					if (mem_ack)
					begin
						// one burst of four words
						if (word_cnt == 3'h0)
							cb_ctl <= mem_rdata;
						else if (word_cnt == 3'h1)
							cb_link <= mem_rdata;
						else if (word_cnt == 3'h2)
							cb_p0 <= mem_rdata;
						else
							cb_p1 <= mem_rdata;
						word_cnt <= word_cnt + 3'h1;
						mem_addr <= mem_addr + 32'h0000_0004;
						if (word_cnt == `CB_WORDS - 3'h1)
						begin
							mem_req <= 1'b0;
							mem_burst <= 1'b0;
							state <= S_DECODE;
						end
					end
				end
				S_DECODE:
				begin
					// link is saved before the action starts
					cb_link <= base_reg + cb_link;
					prefetched_reg <= 1'b0;
					if (!last)
					begin
						mem_addr <= base_reg + cb_link + `CB_CTL_OFS;
						mem_req <= 1'b1;
						state <= S_PREF;
					end
					else
						state <= S_ACT;
				end
				S_PREF:
				begin
					if (mem_ack)
					begin
						// keep last, suspend, interrupt bits and opcode
						next_fields_reg <= {mem_rdata[`CB_EL_BIT], mem_rdata[`CB_S_BIT],
							mem_rdata[`CB_I_BIT], 1'b0};
						prefetched_reg <= 1'b1;
						next_op_reg <= mem_rdata[`CB_OP_HI:`CB_OP_LO];
						mem_req <= 1'b0;
						state <= S_ACT;
					end
				end
				S_ACT:
				begin
					ok_reg <= 1'b1;
					param_data <= {cb_p1, cb_p0};
					state <= S_STWR;
					case (opcode)
						`OP_NOP:
							state <= S_STWR;
						`OP_IA:
							station_addr <= {cb_p1[15:0], cb_p0};
						`OP_CONFIG:
							config_data <= {cb_p1, cb_p0};
						`OP_MCAST:
							mcast_load <= 1'b1;
						`OP_TX:
						begin
							tx_dma_req <= 1'b1;
							state <= S_WAIT;
						end
						`OP_UCODE:
							ucode_load <= 1'b1;
						`OP_DUMP:
						begin
							// registers land at base plus the offset in the first parameter word
							mem_addr <= base_reg + cb_p0;
							mem_wdata <= dump_word(3'h0);
							mem_we <= 1'b1;
							mem_req <= 1'b1;
							word_cnt <= 3'h0;
							state <= S_DUMP;
						end
						default:
						begin
							diag_req <= 1'b1;
							state <= S_WAIT;
						end
					endcase
				end
				S_WAIT:
				begin
					if (tx_dma_req && tx_dma_done)
					begin
						// done at end of buffer dma, not on the wire
						tx_dma_req <= 1'b0;
						state <= S_STWR;
					end
					else if (diag_req && diag_done)
					begin
						diag_req <= 1'b0;
						ok_reg <= ~diag_fail;
						state <= S_STWR;
					end
				end
				S_DUMP:
				begin
					if (mem_ack)
					begin
						word_cnt <= word_cnt + 3'h1;
						mem_addr <= mem_addr + 32'h0000_0004;
						mem_wdata <= dump_word(word_cnt + 3'h1);
						if (word_cnt == `CB_WORDS - 3'h1)
						begin
							mem_req <= 1'b0;
							state <= S_STWR;
						end
					end
				end
				S_STWR:
				begin
					if (!mem_req)
					begin
						// status half only, command half left untouched
						mem_addr <= cb_addr + `CB_CTL_OFS;
						mem_wdata <= {16'h0000, 1'b1, 1'b0, ok_reg, 13'h0000};
						mem_be <= 4'h3;
						mem_we <= 1'b1;
						mem_req <= 1'b1;
					end
					else if (mem_ack)
					begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						mem_be <= 4'hF;
						state <= S_DONE;
					end
				end
				default:
				begin
					// unit is still active here
					completion_interrupt <= cb_ctl[`CB_I_BIT];
					last_status_reg <= {1'b1, 1'b0, ok_reg, 13'h0000};
					if (last)
					begin
						// last-in-list checked first
						cu_state <= `CU_IDLE;
						not_active_interrupt <= 1'b1;
						state <= S_IDLE;
					end
					else if (susp)
					begin
						cu_state <= `CU_SUSP;
						not_active_interrupt <= cna_en_reg;
						cb_addr <= cb_link;
						state <= S_SUSP;
					end
					else if (rx_busy)
					begin
						// chaining waits while the receive side holds the bus
						state <= S_DONE;
						completion_interrupt <= 1'b0;
					end
					else
					begin
						// next block in chain order
						cb_addr <= cb_link;
						mem_addr <= cb_link + `CB_CTL_OFS;
						mem_req <= 1'b1;
						mem_burst <= 1'b1;
						word_cnt <= 3'h0;
						state <= S_FETCH;
					end
				end
			endcase
		end
	end
endmodule

//--- verif/cce_properties.sv
// port checker for the command chain sequencer
`timescale 1ns/10ps
`include "cu_chain_defines.vh"
module cce_properties
(
	// clock and reset
	input wire        core_clk,
	input wire        rst_n,
	// watched ports
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        mem_req,
	input wire        mem_we,
	input wire        mem_burst,
	input wire [3:0]  mem_be,
	input wire [31:0] mem_addr,
	input wire [31:0] mem_wdata,
	input wire        mem_ack,
	input wire        rx_busy,
	input wire        tx_dma_req,
	input wire        tx_dma_done,
	input wire        completion_interrupt,
	input wire        not_active_interrupt,
	input wire [1:0]  cu_state
);
	// ==========================================
	// assertions
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_zero_wait: assert property (psel && penable |-> pready) else $error("apb access stalled");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request dropped or changed");
	a_burst_step: assert property (mem_ack && mem_burst |=> mem_addr == $past(mem_addr) + 32'h4)
		else $error("burst address did not step");
	a_burst_read: assert property ($rose(mem_burst) |-> mem_req && !mem_we)
		else $error("burst is not a read");
	a_status_done: assert property (mem_req && mem_we && mem_be == 4'h3 |-> mem_wdata[`CB_C_BIT])
		else $error("status write without complete bit");
	a_cx_active: assert property (completion_interrupt |-> $past(cu_state) == `CU_ACTIVE)
		else $error("completion pulse while not active");
	a_cna_cause: assert property (not_active_interrupt |->
		$past(cu_state) == `CU_ACTIVE && cu_state != `CU_ACTIVE)
		else $error("not-active pulse without leaving active");
	a_idle_cna: assert property ($changed(cu_state) && cu_state == `CU_IDLE |-> not_active_interrupt)
		else $error("went idle without not-active pulse");
	a_rx_holds: assert property (rx_busy && cu_state != `CU_ACTIVE |=> cu_state != `CU_ACTIVE)
		else $error("started while receive busy");
	a_tx_hold: assert property (tx_dma_req && !tx_dma_done |=> tx_dma_req)
		else $error("transmit dma request dropped early");

	c_done: cover property (completion_interrupt);
	c_idle: cover property (not_active_interrupt && cu_state == `CU_IDLE);
	c_susp: cover property ($rose(cu_state == `CU_SUSP));
endmodule

bind command_chain_executor cce_properties i_props (.core_clk, .rst_n, .psel, .penable, .pready, .mem_req,
	.mem_we, .mem_burst, .mem_be, .mem_addr, .mem_wdata, .mem_ack, .rx_busy, .tx_dma_req, .tx_dma_done,
	.completion_interrupt, .not_active_interrupt, .cu_state);

//--- verif/host_mem_model.sv
// host memory holding the command chain
`timescale 1ns/10ps
module host_mem_model
(
	// clock
	input  wire         core_clk,
	// memory port
	input  wire         mem_req,
	input  wire         mem_we,
	input  wire [3:0]   mem_be,
	input  wire [31:0]  mem_addr,
	input  wire [31:0]  mem_wdata,
	output logic        mem_ack,
	output logic [31:0] mem_rdata,
	// pacing
	input  wire         slow
);
	// ==========================================
	// storage and answer
	logic [31:0] mem [0:63];
	logic [1:0]  wait_cnt;
	wire  [31:0] mask = {{8{mem_be[3]}}, {8{mem_be[2]}}, {8{mem_be[1]}}, {8{mem_be[0]}}};

	initial
	begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		wait_cnt = 2'h0;
	end

	// block layout and cleared complete bits come from the bench
	always @(posedge core_clk)
	begin
		mem_ack <= 1'b0;
		// data lines toggle between words so stale data never looks valid
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack)
		begin
			wait_cnt <= wait_cnt + 2'h1;
			if (!slow || wait_cnt == 2'h3)
			begin
				mem_ack <= 1'b1;
				wait_cnt <= 2'h0;
				if (mem_we)
					mem[mem_addr[7:2]] <= (mem[mem_addr[7:2]] & ~mask) | (mem_wdata & mask);
				else
					mem_rdata <= mem[mem_addr[7:2]];
			end
		end
	end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the command chain sequencer
`timescale 1ns/10ps
`include "cu_chain_defines.vh"
module tb_top;
	logic        core_clk = 1'b0;
	logic        rst_n, psel, penable, pwrite, pready, pslverr, slow, e;
	logic [4:0]  paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, q;
	logic        mem_req, mem_we, mem_burst, mem_ack, rx_busy, phy_mode_strap;
	logic [3:0]  mem_be;
	logic        tx_dma_req, tx_dma_done, tx_frame_sent, diag_req, diag_done, diag_fail;
	logic        ucode_load, mcast_load, completion_interrupt, not_active_interrupt;
	logic [63:0] param_data, config_data;
	logic [47:0] station_addr;
	logic [1:0]  cu_state;
	int          miscompares, check_count, cx_cnt, cna_cnt, ld_cnt;

	command_chain_executor i_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .mem_req, .mem_we, .mem_burst, .mem_be, .mem_addr, .mem_wdata, .mem_ack,
		.mem_rdata, .rx_busy, .phy_mode_strap, .tx_dma_req, .tx_dma_done, .tx_frame_sent, .diag_req,
		.diag_done, .diag_fail, .ucode_load, .mcast_load, .param_data, .station_addr, .config_data,
		.completion_interrupt, .not_active_interrupt, .cu_state);
	host_mem_model i_mem (.core_clk, .mem_req, .mem_we, .mem_be, .mem_addr, .mem_wdata, .mem_ack,
		.mem_rdata, .slow);

	always #12.5 core_clk = ~core_clk;

	// ==========================================
	// neighbours and event counters
	always @(posedge core_clk)
	begin
		tx_dma_done <= tx_dma_req && !tx_dma_done;
		diag_done <= diag_req && !diag_done;
		cx_cnt <= cx_cnt + (completion_interrupt === 1'b1);
		cna_cnt <= cna_cnt + (not_active_interrupt === 1'b1);
		ld_cnt <= ld_cnt + (ucode_load === 1'b1) + (mcast_load === 1'b1);
	end

	// ==========================================
	// helpers
	task chk(input string what, input logic [63:0] x, input logic [63:0] y);
		check_count++;
		if (y !== x)
		begin
			miscompares++;
			$display("FAIL %s expected %0h seen %0h", what, x, y);
		end
	endtask

	task apb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		// answer taken at the edge that completes the access
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_state(input logic [1:0] s);
		int n;
		n = 0;
		while (cu_state !== s && n < 3000)
		begin
			@(negedge core_clk);
			n++;
		end
		chk("cu_state", s, cu_state);
		// pulses of the final edge reach the event counters one edge later
		@(negedge core_clk);
	endtask

	task put_block(input int a, input logic [2:0] op, input logic [2:0] esi, input logic [31:0] link,
		input logic [31:0] p0, input logic [31:0] p1);
		i_mem.mem[a / 4] = {esi, 10'h0, op, 16'h0};
		i_mem.mem[a / 4 + 1] = link;
		i_mem.mem[a / 4 + 2] = p0;
		i_mem.mem[a / 4 + 3] = p1;
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================
	// scenarios
	task t_reset;
		chk("station address", `IA_RESET, station_addr);
		chk("phy mode", 1, config_data[`CFG_PHY_BIT]);
		apb(1'b0, 5'h14, 0);
		chk("unmapped error", 1, e);
		chk("unmapped data", 0, q);
		$display("reset test done");
	endtask

	task t_rx_hold;
		// links are relative to base 40h
		put_block(8'h40, `OP_NOP, 3'b001, 32'h10, 0, 0);
		put_block(8'h50, `OP_IA, 3'b000, 32'h20, 32'h4433_2211, 32'h0000_6655);
		put_block(8'h60, `OP_CONFIG, 3'b000, 32'h30, 32'h0000_00F0, 0);
		put_block(8'h70, `OP_MCAST, 3'b010, 32'h40, 32'hA5A5_0001, 2);
		put_block(8'h80, `OP_UCODE, 3'b001, 32'h50, 7, 9);
		put_block(8'h90, `OP_TX, 3'b000, 32'h60, 0, 0);
		put_block(8'hA0, `OP_DUMP, 3'b000, 32'h70, 32'h80, 0);
		put_block(8'hB0, `OP_DIAG, 3'b110, 0, 0, 0);
		rx_busy <= 1'b1;
		apb(1'b1, `CCX_BASE_OFS, 32'h40);
		apb(1'b1, `CCX_PTR_OFS, 0);
		apb(1'b1, `CCX_CTRL_OFS, 1);
		repeat (10) @(posedge core_clk);
		chk("held unit", `CU_IDLE, cu_state);
		chk("held memory", 0, mem_req);
		rx_busy <= 1'b0;
		$display("receive hold test done");
	endtask

	task t_first_chain;
		wait_state(`CU_ACTIVE);
		wait_state(`CU_SUSP);
		chk("completions", 1, cx_cnt);
		chk("not active", 0, cna_cnt);
		chk("address load", 48'h6655_4433_2211, station_addr);
		chk("configuration", 64'h0000_0000_0000_00F0, config_data);
		chk("list loads", 1, ld_cnt);
		chk("parameters", 64'h0000_0002_A5A5_0001, param_data);
		for (int a = 8'h40; a < 8'h80; a += 16)
			chk("status", 16'hA000, i_mem.mem[a / 4][15:0]);
		apb(1'b0, `CCX_STAT_OFS, 0);
		chk("unit status", {1'b1, 4'b0010, `OP_UCODE, 6'h00, `CU_SUSP, 16'hA000}, q);
		$display("first chain test done");
	endtask

	task t_resume_chain;
		slow <= 1'b1;
		apb(1'b1, `CCX_CTRL_OFS, 32'h6);
		wait_state(`CU_ACTIVE);
		wait_state(`CU_IDLE);
		chk("not active", 1, cna_cnt);
		chk("completions", 2, cx_cnt);
		chk("loads", 2, ld_cnt);
		for (int a = 8'h80; a < 8'hB0; a += 16)
			chk("status", 16'hA000, i_mem.mem[a / 4][15:0]);
		chk("diag status", 16'h8000, i_mem.mem[8'hB0 / 4][15:0]);
		chk("dump config", 32'h0000_00F0, i_mem.mem[8'hC0 / 4]);
		chk("dump address", 32'h4433_2211, i_mem.mem[8'hC8 / 4]);
		chk("dump address top", 32'h0000_6655, i_mem.mem[8'hCC / 4]);
		apb(1'b0, `CCX_TXCNT_OFS, 0);
		chk("frames before", 0, q);
		tx_frame_sent <= 1'b1;
		@(posedge core_clk);
		tx_frame_sent <= 1'b0;
		apb(1'b0, `CCX_TXCNT_OFS, 0);
		chk("frames after", 1, q);
		$display("resume chain test done");
	endtask

	task t_diag_pass;
		// passing self-test, then suspend with the not-active enable still set
		put_block(8'hD0, `OP_DIAG, 3'b010, 0, 0, 0);
		diag_fail <= 1'b0;
		apb(1'b1, `CCX_PTR_OFS, 32'h90);
		apb(1'b1, `CCX_CTRL_OFS, 32'h5);
		wait_state(`CU_ACTIVE);
		wait_state(`CU_SUSP);
		chk("diag pass status", 16'hA000, i_mem.mem[8'hD0 / 4][15:0]);
		chk("not active on suspend", 2, cna_cnt);
		chk("no completion pulse", 2, cx_cnt);
		$display("diagnose pass test done");
	endtask

	initial
	begin
		#(25 * 20000);
		miscompares++;
		give_verdict;
	end

	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 5'h00;
		pwdata = 32'h0;
		slow = 1'b0;
		rx_busy = 1'b0;
		phy_mode_strap = 1'b1;
		tx_frame_sent = 1'b0;
		diag_fail = 1'b1;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset;
		t_rx_hold;
		t_first_chain;
		t_resume_chain;
		t_diag_pass;
		give_verdict;
	end
endmodule
